// ---- core/csi_ctrl_status_indirect_regs.sv ----
// indirect pointer, data port decode, main status/interrupt register, pm config bytes
// assumes i/o and config strobes are one-cycle pulses synchronous to clock; the
// other control/status and bus configuration registers live outside and answer
// combinationally to the index outputs
//
// Contract
// - config byte 46h reads as constant zero.
// - config byte 47h returns the eeprom-loaded power report value.
// - low pointer byte indexes control space and bus config space.
// - pointer at 12h word or 14h dword; control data at 10h.
// - bus config data at 16h word or 1Ch dword, same index.
// - pointer bits 15:8 read zero; bits 31:16 read zero here.
// - pointer always accessible, cleared by resets, kept through stop.
// - writing one clears a cause flag; write-back of read acknowledges.
// - error summary is or of collision, missed, timeout; writes ignored.
// - bit 14 reads zero; collision test fails after 20 quiet bit times.
// - on mii only half-duplex 10base-t checks; never interrupts.
// - dropped frame sets missed flag and bumps missed frame counter.
// - missed/timeout set summary; interrupt only if enabled and unmasked.
// - ungranted bus request beyond timeout sets timeout error flag.
// - init done sets flag; interrupts if enabled and unmasked.
// - rx flag on last descriptor, or first with early notify.
// - tx flag on last descriptor unless successful and suppressed.
// - pending flag is or of all unmasked causes; the collision test error is left out of it here.
// - enable written directly; cleared by resets and stop.
// - event flags ignore zero writes; cleared by resets and stop.
`timescale 1ns/1ps
module csi_ctrl_status_indirect_regs (
	input  wire logic        clock,
	input  wire logic        resetn,
	input  wire logic        soft_reset,
	input  wire logic        stop_set,
	input  wire logic        dword_io_mode,
	input  wire logic [4:0]  io_addr,
	input  wire logic        io_wr,
	input  wire logic        io_rd,
	input  wire logic [31:0] io_wdata,
	output logic      [31:0] io_rdata_q,
	output logic             io_rvalid_q,
	output logic      [7:0]  reg_index_q,
	output logic             csr_wr_q,
	output logic             bcr_wr_q,
	output logic      [31:0] ext_wdata_q,
	input  wire logic [31:0] ext_csr_rdata,
	input  wire logic [31:0] ext_bcr_rdata,
	input  wire logic [5:0]  run_ctrl_status,
	input  wire logic [7:0]  cfg_addr,
	input  wire logic        cfg_rd,
	output logic      [7:0]  cfg_rdata_q,
	input  wire logic [7:0]  pm_report_value,
	input  wire logic        half_duplex,
	input  wire logic        mii_selected,
	input  wire logic        phy_10bt_half,
	input  wire logic        tx_end,
	input  wire logic        collision_in,
	input  wire logic        bit_tick,
	input  wire logic        missed_frame_evt,
	input  wire logic        bus_req,
	input  wire logic        bus_gnt,
	input  wire logic [15:0] bus_timeout_register,
	input  wire logic        init_done_evt,
	input  wire logic        rx_last_desc_evt,
	input  wire logic        rx_first_desc_evt,
	input  wire logic        early_rx_notify_enable,
	input  wire logic        tx_last_desc_evt,
	input  wire logic        tx_ok,
	input  wire logic        suppress_ok_tx_event,
	input  wire logic        missed_frame_mask,
	input  wire logic        bus_timeout_mask,
	input  wire logic        rx_event_mask,
	input  wire logic        tx_event_mask,
	input  wire logic        init_done_mask,
	input  wire logic        other_interrupt_pending_causes,
	input  wire logic        system_error_event,
	input  wire logic        sleep_event,
	output logic      [15:0] missed_frame_counter_q,
	output logic             interrupt_pending_line_n_q
);
	// ------------------------------------------------------------
	// decode
	// ------------------------------------------------------------
	logic [4:0] ptr_off, bus_cfg_off;
	logic       ptr_hit, ctrl_hit, bus_cfg_hit, main_sel, main_wr, clr_all;

	assign ptr_off     = dword_io_mode ? csi_pkg::IO_PTR_DWORD : csi_pkg::IO_PTR_WORD;
	assign bus_cfg_off = dword_io_mode ? csi_pkg::IO_BUS_CFG_DWORD
	                                   : csi_pkg::IO_BUS_CFG_WORD;
	assign ptr_hit     = io_addr == ptr_off;
	assign ctrl_hit    = io_addr == csi_pkg::IO_CTRL_DATA;
	assign bus_cfg_hit = io_addr == bus_cfg_off;
	assign main_sel    = reg_index_q == csi_pkg::MAIN_STATUS_INDEX;
	assign main_wr     = io_wr && ctrl_hit && main_sel;
	assign clr_all     = soft_reset || stop_set;

	// ------------------------------------------------------------
	// register pointer
	// ------------------------------------------------------------
	// only the index byte is stored, so upper bits cannot leak back on reads
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			reg_index_q <= 8'h00;
		end else if (soft_reset) begin
			reg_index_q <= 8'h00;
		end else if (io_wr && ptr_hit) begin
			reg_index_q <= io_wdata[7:0];
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			csr_wr_q    <= 1'b0;
			bcr_wr_q    <= 1'b0;
			ext_wdata_q <= 32'h00000000;
		end else begin
			csr_wr_q <= io_wr && ctrl_hit && !main_sel;
			bcr_wr_q <= io_wr && bus_cfg_hit;
			if (io_wr) begin
				ext_wdata_q <= io_wdata;
			end
		end
	end

	// ------------------------------------------------------------
	// event flags
	// ------------------------------------------------------------
	logic collision_test_error_q, miss_q, bus_timeout_error_q, rx_interrupt_flag_q, tx_interrupt_flag_q, init_done_flag_q, interrupt_output_enable_q;
	logic collision_test_error_set, bus_timeout_error_set, rx_interrupt_flag_set, tx_interrupt_flag_set;
	// flag update: stop or soft reset clears, otherwise set wins over w1c
	function automatic logic flag_next(logic cur, logic set, logic clr_bit, logic wr,
	                                   logic clr);
		if (clr) begin
			return 1'b0;
		end
		if (set) begin
			return 1'b1;
		end
		return cur && !(wr && clr_bit);
	endfunction

	assign rx_interrupt_flag_set = rx_last_desc_evt || (rx_first_desc_evt && early_rx_notify_enable);
	assign tx_interrupt_flag_set = tx_last_desc_evt && !(tx_ok && suppress_ok_tx_event);
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			{collision_test_error_q, miss_q, bus_timeout_error_q, rx_interrupt_flag_q, tx_interrupt_flag_q, init_done_flag_q} <= 6'h00;
		end else begin
			collision_test_error_q <= flag_next(collision_test_error_q, collision_test_error_set, io_wdata[csi_pkg::B_COLLISION_TEST_ERROR], main_wr,
			                    clr_all);
			miss_q <= flag_next(miss_q, missed_frame_evt, io_wdata[csi_pkg::B_MISS],
			                    main_wr, clr_all);
			bus_timeout_error_q <= flag_next(bus_timeout_error_q, bus_timeout_error_set, io_wdata[csi_pkg::B_BUS_TIMEOUT_ERROR], main_wr,
			                    clr_all);
			rx_interrupt_flag_q <= flag_next(rx_interrupt_flag_q, rx_interrupt_flag_set, io_wdata[csi_pkg::B_RX_INTERRUPT_FLAG], main_wr,
			                    clr_all);
			tx_interrupt_flag_q <= flag_next(tx_interrupt_flag_q, tx_interrupt_flag_set, io_wdata[csi_pkg::B_TX_INTERRUPT_FLAG], main_wr,
			                    clr_all);
			init_done_flag_q <= flag_next(init_done_flag_q, init_done_evt, io_wdata[csi_pkg::B_INIT_DONE_FLAG],
			                    main_wr, clr_all);
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			interrupt_output_enable_q <= 1'b0;
		end else if (clr_all) begin
			interrupt_output_enable_q <= 1'b0;
		end else if (main_wr) begin
			interrupt_output_enable_q <= io_wdata[csi_pkg::B_INTERRUPT_OUTPUT_ENABLE];
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			missed_frame_counter_q <= 16'h0000;
		end else if (soft_reset) begin
			missed_frame_counter_q <= 16'h0000;
		end else if (missed_frame_evt) begin
			missed_frame_counter_q <= missed_frame_counter_q + 16'h0001;
		end
	end

	// ------------------------------------------------------------
	// collision test
	// ------------------------------------------------------------
	logic       col_armed_q, col_check_en;
	logic [4:0] col_cnt_q;
	// full duplex never checks; on mii only a half-duplex 10base-t phy does
	assign col_check_en = half_duplex && (!mii_selected || phy_10bt_half);
	assign collision_test_error_set     = col_armed_q && bit_tick && !collision_in &&
	                      (col_cnt_q == csi_pkg::COL_TEST_BITS - 5'h01);

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			col_armed_q <= 1'b0;
			col_cnt_q   <= 5'h00;
		end else if (tx_end && col_check_en) begin
			col_armed_q <= 1'b1;
			col_cnt_q   <= 5'h00;
		end else if (col_armed_q && (collision_in || !col_check_en || collision_test_error_set)) begin
			col_armed_q <= 1'b0;
		end else if (col_armed_q && bit_tick) begin
			col_cnt_q <= col_cnt_q + 5'h01;
		end
	end

	// ------------------------------------------------------------
	// bus grant timeout
	// ------------------------------------------------------------
	logic [15:0] tmo_cnt_q;
	logic [15:0] tmo_limit;
	// a zero register would never fire, so it falls back to the default
	assign tmo_limit = (bus_timeout_register == 16'h0000) ? csi_pkg::BUS_TMO_DEFAULT
	                                                      : bus_timeout_register;
	assign bus_timeout_error_set  = bus_req && !bus_gnt && (tmo_cnt_q == tmo_limit - 16'h0001);

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			tmo_cnt_q <= 16'h0000;
		end else if (!bus_req || bus_gnt) begin
			tmo_cnt_q <= 16'h0000;
		end else if (tmo_cnt_q != tmo_limit) begin
			tmo_cnt_q <= tmo_cnt_q + 16'h0001;
		end
	end

	// ------------------------------------------------------------
	// interrupt summary and line
	// ------------------------------------------------------------
	logic err_sum, interrupt_pending_pending, wake_cause;
	assign err_sum      = collision_test_error_q || miss_q || bus_timeout_error_q;
	assign wake_cause   = system_error_event || sleep_event;
	// collision test error deliberately absent from the pending term
	assign interrupt_pending_pending = (miss_q && !missed_frame_mask) || (bus_timeout_error_q && !bus_timeout_mask) ||
	                      (rx_interrupt_flag_q && !rx_event_mask) || (tx_interrupt_flag_q && !tx_event_mask) ||
	                      (init_done_flag_q && !init_done_mask) || other_interrupt_pending_causes ||
	                      wake_cause;

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			interrupt_pending_line_n_q <= 1'b1;
		end else begin
			interrupt_pending_line_n_q <= !(interrupt_pending_pending && (interrupt_output_enable_q || wake_cause));
		end
	end

	// ------------------------------------------------------------
	// read paths
	// ------------------------------------------------------------
	logic [31:0] main_rd;
	always_comb begin
		main_rd                    = 32'h00000000;
		main_rd[csi_pkg::B_ERR]    = err_sum;
		main_rd[csi_pkg::B_RSVD]   = 1'b0;
		main_rd[csi_pkg::B_COLLISION_TEST_ERROR]   = collision_test_error_q;
		main_rd[csi_pkg::B_MISS]   = miss_q;
		main_rd[csi_pkg::B_BUS_TIMEOUT_ERROR]   = bus_timeout_error_q;
		main_rd[csi_pkg::B_RX_INTERRUPT_FLAG]   = rx_interrupt_flag_q;
		main_rd[csi_pkg::B_TX_INTERRUPT_FLAG]   = tx_interrupt_flag_q;
		main_rd[csi_pkg::B_INIT_DONE_FLAG]   = init_done_flag_q;
		main_rd[csi_pkg::B_INTERRUPT_PENDING]   = interrupt_pending_pending;
		main_rd[csi_pkg::B_INTERRUPT_OUTPUT_ENABLE]   = interrupt_output_enable_q;
		main_rd[csi_pkg::RUN_CTRL_W-1:0] = run_ctrl_status;
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			io_rdata_q  <= 32'h00000000;
			io_rvalid_q <= 1'b0;
		end else begin
			io_rvalid_q <= io_rd;
			if (io_rd) begin
				if (ptr_hit) begin
					io_rdata_q <= {24'h000000, reg_index_q};
				end else if (ctrl_hit) begin
					io_rdata_q <= main_sel ? main_rd : ext_csr_rdata;
				end else if (bus_cfg_hit) begin
					io_rdata_q <= ext_bcr_rdata;
				end else begin
					io_rdata_q <= 32'h00000000;
				end
			end
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			cfg_rdata_q <= 8'h00;
		end else if (cfg_rd) begin
			if (cfg_addr == csi_pkg::CFG_PM_BRIDGE_EXT) begin
				cfg_rdata_q <= csi_pkg::PM_BRIDGE_EXT_VAL;
			end else if (cfg_addr == csi_pkg::CFG_PM_REPORT) begin
				cfg_rdata_q <= pm_report_value;
			end else begin
				cfg_rdata_q <= 8'h00;
			end
		end
	end

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (!resetn);
	sequence ptr_load_s;
		io_wr && ptr_hit && !soft_reset;
	endsequence
	sequence main_read_s;
		io_rd && ctrl_hit && main_sel;
	endsequence
	bridge_ext_zero_a: assert property (cfg_rd && cfg_addr == csi_pkg::CFG_PM_BRIDGE_EXT
		|=> cfg_rdata_q == 8'h00) else $error("bridge ext byte not zero");
	report_byte_a: assert property (cfg_rd && cfg_addr == csi_pkg::CFG_PM_REPORT
		|=> cfg_rdata_q == $past(pm_report_value)) else $error("pm report byte wrong");
	ptr_load_read_a: assert property (ptr_load_s ##1 (io_rd && ptr_hit)
		|=> io_rdata_q == {24'h000000, $past(io_wdata[7:0], 2)})
		else $error("pointer readback wrong");
	ptr_stop_hold_a: assert property (stop_set && !soft_reset && !(io_wr && ptr_hit)
		|=> $stable(reg_index_q)) else $error("pointer changed on stop");
	err_summary_a: assert property (main_read_s |=>
		io_rdata_q[csi_pkg::B_ERR] == $past(collision_test_error_q || miss_q || bus_timeout_error_q) &&
		!io_rdata_q[csi_pkg::B_RSVD]) else $error("error summary wrong");
	w1c_ack_a: assert property (main_wr && io_wdata[csi_pkg::B_MISS] && !missed_frame_evt
		|=> !miss_q) else $error("missed flag not acknowledged");
	set_wins_a: assert property (missed_frame_evt && !clr_all |=> miss_q &&
		missed_frame_counter_q == $past(missed_frame_counter_q) + 16'h0001)
		else $error("missed frame lost");
	stop_clears_a: assert property (stop_set |=> !interrupt_output_enable_q && !collision_test_error_q && !miss_q &&
		!bus_timeout_error_q && !init_done_flag_q && !rx_interrupt_flag_q && !tx_interrupt_flag_q) else $error("stop did not clear");
	collision_test_error_quiet_a: assert property (collision_test_error_q && !miss_q && !bus_timeout_error_q && !rx_interrupt_flag_q && !tx_interrupt_flag_q &&
		!init_done_flag_q && !other_interrupt_pending_causes && !wake_cause |-> !interrupt_pending_pending)
		else $error("collision error interrupted");
	line_gate_a: assert property (!interrupt_output_enable_q && !wake_cause |=> interrupt_pending_line_n_q)
		else $error("line active while disabled");
	line_follow_a: assert property (interrupt_pending_pending && interrupt_output_enable_q |=> !interrupt_pending_line_n_q)
		else $error("line missed pending cause");
	timeout_a: assert property (bus_req && !bus_gnt &&
		tmo_cnt_q == tmo_limit - 16'h0001 && !clr_all |=> bus_timeout_error_q)
		else $error("bus timeout not flagged");
endmodule

// ---- core/csi_pkg.sv ----
// constants for the indirect register access and main status block
// assumes a 10 MHz clock and byte addresses on the 5-bit i/o offset bus
package csi_pkg;
	// ------------------------------------------------------------
	// clock and timing
	// ------------------------------------------------------------
	localparam int unsigned CLOCK_HZ          = 10_000_000;
	localparam int unsigned CLOCK_PERIOD_NS   = 1_000_000_000 / CLOCK_HZ;
	// default bus grant timeout, 153.6 us, expressed in ns
	localparam int unsigned BUS_TMO_DEFAULT_NS  = 153_600;
	localparam int unsigned BUS_TMO_DEFAULT_CYC = BUS_TMO_DEFAULT_NS / CLOCK_PERIOD_NS;
	localparam logic [15:0] BUS_TMO_DEFAULT     = 16'(BUS_TMO_DEFAULT_CYC);
	// sqe test window in network bit times
	localparam logic [4:0]  COL_TEST_BITS       = 5'h14;

	// ------------------------------------------------------------
	// i/o offsets
	// ------------------------------------------------------------
	localparam logic [4:0] IO_CTRL_DATA      = 5'h10;
	localparam logic [4:0] IO_PTR_WORD       = 5'h12;
	localparam logic [4:0] IO_PTR_DWORD      = 5'h14;
	localparam logic [4:0] IO_BUS_CFG_WORD   = 5'h16;
	localparam logic [4:0] IO_BUS_CFG_DWORD  = 5'h1C;

	// ------------------------------------------------------------
	// configuration space offsets
	// ------------------------------------------------------------
	localparam logic [7:0] CFG_PM_BRIDGE_EXT = 8'h46;
	localparam logic [7:0] CFG_PM_REPORT     = 8'h47;
	localparam logic [7:0] PM_BRIDGE_EXT_VAL = 8'h00;

	// ------------------------------------------------------------
	// main status register layout
	// ------------------------------------------------------------
	localparam logic [7:0] MAIN_STATUS_INDEX = 8'h00;
	localparam int unsigned B_ERR   = 15;
	localparam int unsigned B_RSVD  = 14;
	localparam int unsigned B_COLLISION_TEST_ERROR  = 13;
	localparam int unsigned B_MISS  = 12;
	localparam int unsigned B_BUS_TIMEOUT_ERROR  = 11;
	localparam int unsigned B_RX_INTERRUPT_FLAG  = 10;
	localparam int unsigned B_TX_INTERRUPT_FLAG  = 9;
	localparam int unsigned B_INIT_DONE_FLAG  = 8;
	localparam int unsigned B_INTERRUPT_PENDING  = 7;
	localparam int unsigned B_INTERRUPT_OUTPUT_ENABLE  = 6;
	localparam int unsigned RUN_CTRL_W = 6;
endpackage

// ---- test/testbench.sv ----
// self-checking bench for the indirect pointer and main status block
// assumes the design's own assertions run alongside; inputs change at falling edges
`timescale 1ns/1ps
module testbench;
	// ------------------------------------------------------------
	// stimulus and design
	// ------------------------------------------------------------
	logic        clock, resetn, soft_reset, stop_set, dword_io_mode, io_wr, io_rd;
	logic [4:0]  io_addr;
	logic [31:0] io_wdata, io_rdata_q;
	logic        io_rvalid_q, csr_wr_q, bcr_wr_q, cfg_rd, interrupt_pending_line_n_q;
	logic [7:0]  reg_index_q, cfg_addr, cfg_rdata_q;
	logic [31:0] ext_wdata_q;
	logic        half_duplex, mii_selected, phy_10bt_half, tx_end, collision_in, bit_tick;
	logic        missed_frame_evt, bus_req, bus_gnt, init_done_evt, rx_last_desc_evt;
	logic        rx_first_desc_evt, early_rx_notify_enable, tx_last_desc_evt, tx_ok;
	logic        suppress_ok_tx_event, missed_frame_mask, system_error_event, sleep_event;
	logic        bus_timeout_mask, rx_event_mask, tx_event_mask, init_done_mask;
	logic [15:0] bus_timeout_register, missed_frame_counter_q;
	int          error_cnt, checked;

	csi_ctrl_status_indirect_regs dut (.clock(clock), .resetn(resetn),
		.soft_reset(soft_reset), .stop_set(stop_set), .dword_io_mode(dword_io_mode),
		.io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata),
		.io_rdata_q(io_rdata_q), .io_rvalid_q(io_rvalid_q), .reg_index_q(reg_index_q),
		.csr_wr_q(csr_wr_q), .bcr_wr_q(bcr_wr_q), .ext_wdata_q(ext_wdata_q),
		.ext_csr_rdata(32'h1111_2222), .ext_bcr_rdata(32'h3333_4444),
		.run_ctrl_status(6'h2A), .cfg_addr(cfg_addr), .cfg_rd(cfg_rd),
		.cfg_rdata_q(cfg_rdata_q), .pm_report_value(8'hA5), .half_duplex(half_duplex),
		.mii_selected(mii_selected), .phy_10bt_half(phy_10bt_half), .tx_end(tx_end),
		.collision_in(collision_in), .bit_tick(bit_tick), .missed_frame_evt(missed_frame_evt),
		.bus_req(bus_req), .bus_gnt(bus_gnt), .bus_timeout_register(bus_timeout_register),
		.init_done_evt(init_done_evt), .rx_last_desc_evt(rx_last_desc_evt),
		.rx_first_desc_evt(rx_first_desc_evt), .early_rx_notify_enable(early_rx_notify_enable),
		.tx_last_desc_evt(tx_last_desc_evt), .tx_ok(tx_ok),
		.suppress_ok_tx_event(suppress_ok_tx_event), .missed_frame_mask(missed_frame_mask),
		.bus_timeout_mask(bus_timeout_mask), .rx_event_mask(rx_event_mask),
		.tx_event_mask(tx_event_mask), .init_done_mask(init_done_mask),
		.other_interrupt_pending_causes(1'b0),
		.system_error_event(system_error_event), .sleep_event(sleep_event),
		.missed_frame_counter_q(missed_frame_counter_q), .interrupt_pending_line_n_q(interrupt_pending_line_n_q));

	initial begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end

	// ------------------------------------------------------------
	// access tasks
	// ------------------------------------------------------------
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			$display("ERROR %s expected %h seen %h", nm, exp, got);
			error_cnt++;
		end
	endtask

	task automatic io_write(input logic [4:0] a, input logic [31:0] d);
		io_addr = a;
		io_wdata = d;
		io_wr = 1'b1;
		@(negedge clock);
		io_wr = 1'b0;
	endtask

	// answer is registered at the taking edge, so it is seen at the next falling edge
	task automatic io_read(input logic [4:0] a, input logic [31:0] exp, input string nm);
		io_addr = a;
		io_rd = 1'b1;
		@(negedge clock);
		io_rd = 1'b0;
		chk("io_rvalid_q", 32'h0000_0001, {31'h0, io_rvalid_q});
		chk(nm, exp, io_rdata_q);
	endtask

	task automatic cfg_read(input logic [7:0] a, input logic [7:0] exp);
		cfg_addr = a;
		cfg_rd = 1'b1;
		@(negedge clock);
		cfg_rd = 1'b0;
		chk("cfg_rdata_q", {24'h0, exp}, {24'h0, cfg_rdata_q});
	endtask

	// one-cycle pulse on the event input picked by k
	task automatic pulse(input int k);
		case (k)
			0: missed_frame_evt = 1'b1;
			1: init_done_evt = 1'b1;
			2: rx_last_desc_evt = 1'b1;
			3: rx_first_desc_evt = 1'b1;
			4: tx_last_desc_evt = 1'b1;
			5: tx_end = 1'b1;
			6: bit_tick = 1'b1;
			7: stop_set = 1'b1;
			default: soft_reset = 1'b1;
		endcase
		@(negedge clock);
		{missed_frame_evt, init_done_evt, rx_last_desc_evt, rx_first_desc_evt} = 4'h0;
		{tx_last_desc_evt, tx_end, bit_tick, stop_set, soft_reset} = 5'h00;
	endtask

	// raise an event, check status and line, then acknowledge by writing back
	task automatic ev(input int k, input logic [31:0] exp);
		pulse(k);
		@(negedge clock);
		chk("interrupt_pending_line_n_q", {31'h0, ~(exp[7] & exp[6])}, {31'h0, interrupt_pending_line_n_q});
		io_read(5'h10, exp, "main_status");
		io_write(5'h10, exp);
		@(negedge clock);
		chk("interrupt_pending_line_n_q", 32'h0000_0001, {31'h0, interrupt_pending_line_n_q});
		io_read(5'h10, 32'h0000_006A, "main_status");
	endtask

	// one transmission end followed by twenty bit ticks, with collision_in left as the caller set it
	task automatic coll_run(input logic hd, input logic mii, input logic p10,
		input logic [31:0] exp);
		{half_duplex, mii_selected, phy_10bt_half} = {hd, mii, p10};
		pulse(5);
		repeat (20) pulse(6);
		@(negedge clock);
		io_read(5'h10, exp, "main_status");
		io_write(5'h10, 32'h0000_2040);
	endtask

	task automatic close_out();
		$display("comparisons %0d mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		error_cnt = 0;
		checked = 0;
		{resetn, soft_reset, stop_set, dword_io_mode, io_wr, io_rd, cfg_rd} = 7'h00;
		{io_addr, io_wdata, cfg_addr, bus_timeout_register} = '0;
		{half_duplex, mii_selected, phy_10bt_half, tx_end, collision_in, bit_tick} = 6'h00;
		{missed_frame_evt, bus_req, bus_gnt, init_done_evt, rx_last_desc_evt} = 5'h00;
		{rx_first_desc_evt, early_rx_notify_enable, tx_last_desc_evt, tx_ok} = 4'h0;
		{suppress_ok_tx_event, missed_frame_mask, system_error_event, sleep_event} = 4'h0;
		{bus_timeout_mask, rx_event_mask, tx_event_mask, init_done_mask} = 4'h0;
		repeat (12) @(negedge clock);
		resetn = 1'b1;
		@(negedge clock);
		io_read(5'h12, 32'h0000_0000, "register_pointer");
		cfg_read(8'h46, 8'h00);
		cfg_read(8'h47, 8'hA5);
		io_write(5'h12, 32'hFFFF_FF05);
		chk("reg_index_q", 32'h0000_0005, {24'h0, reg_index_q});
		io_read(5'h12, 32'h0000_0005, "register_pointer");
		io_read(5'h10, 32'h1111_2222, "ctrl_data_port");
		io_read(5'h16, 32'h3333_4444, "bus_cfg_data_port");
		io_read(5'h06, 32'h0000_0000, "unmapped");
		io_write(5'h10, 32'hDEAD_BEEF);
		chk("csr_wr_q", {31'h0, 1'b1}, {31'h0, csr_wr_q});
		chk("ext_wdata_q", 32'hDEAD_BEEF, ext_wdata_q);
		io_write(5'h16, 32'h0000_1234);
		chk("bcr_wr_q", {31'h0, 1'b1}, {31'h0, bcr_wr_q});
		dword_io_mode = 1'b1;
		io_write(5'h14, 32'h0000_0007);
		chk("reg_index_q", 32'h0000_0007, {24'h0, reg_index_q});
		io_read(5'h1C, 32'h3333_4444, "bus_cfg_data_port");
		dword_io_mode = 1'b0;
		io_write(5'h12, 32'h0000_0000);
		io_write(5'h10, 32'h0000_0040);
		io_read(5'h10, 32'h0000_006A, "main_status");
		ev(0, 32'h0000_90EA);
		chk("missed_frame_counter_q", 32'h0000_0001, {16'h0, missed_frame_counter_q});
		missed_frame_mask = 1'b1;
		ev(0, 32'h0000_906A);
		missed_frame_mask = 1'b0;
		pulse(1);
		io_write(5'h10, 32'h0000_0040);
		io_read(5'h10, 32'h0000_01EA, "main_status");
		io_write(5'h10, 32'h0000_0140);
		ev(3, 32'h0000_006A);
		early_rx_notify_enable = 1'b1;
		ev(3, 32'h0000_04EA);
		ev(2, 32'h0000_04EA);
		{suppress_ok_tx_event, tx_ok} = 2'b11;
		ev(4, 32'h0000_006A);
		tx_ok = 1'b0;
		ev(4, 32'h0000_02EA);
		ev(1, 32'h0000_01EA);
		// masked causes still show their flags but must leave pending and the line alone
		{rx_event_mask, tx_event_mask, init_done_mask} = 3'b111;
		ev(2, 32'h0000_046A);
		ev(4, 32'h0000_026A);
		ev(1, 32'h0000_016A);
		{rx_event_mask, tx_event_mask, init_done_mask} = 3'b000;
		bus_timeout_register = 16'h000A;
		{bus_req, bus_gnt} = 2'b11;
		repeat (15) @(negedge clock);
		io_read(5'h10, 32'h0000_006A, "main_status");
		bus_gnt = 1'b0;
		repeat (4) @(negedge clock);
		io_read(5'h10, 32'h0000_006A, "main_status");
		repeat (10) @(negedge clock);
		bus_req = 1'b0;
		io_read(5'h10, 32'h0000_88EA, "main_status");
		chk("interrupt_pending_line_n_q", 32'h0000_0000, {31'h0, interrupt_pending_line_n_q});
		bus_timeout_mask = 1'b1;
		io_read(5'h10, 32'h0000_886A, "main_status");
		chk("interrupt_pending_line_n_q", 32'h0000_0001, {31'h0, interrupt_pending_line_n_q});
		bus_timeout_mask = 1'b0;
		io_write(5'h10, 32'h0000_0840);
		coll_run(1'b1, 1'b0, 1'b0, 32'h0000_A06A);
		chk("interrupt_pending_line_n_q", 32'h0000_0001, {31'h0, interrupt_pending_line_n_q});
		coll_run(1'b0, 1'b0, 1'b0, 32'h0000_006A);
		coll_run(1'b1, 1'b1, 1'b0, 32'h0000_006A);
		coll_run(1'b1, 1'b1, 1'b1, 32'h0000_A06A);
		collision_in = 1'b1;
		coll_run(1'b1, 1'b0, 1'b0, 32'h0000_006A);
		collision_in = 1'b0;
		pulse(1);
		io_write(5'h12, 32'h0000_0003);
		pulse(7);
		io_read(5'h12, 32'h0000_0003, "register_pointer");
		io_write(5'h12, 32'h0000_0000);
		io_read(5'h10, 32'h0000_002A, "main_status");
		for (int i = 0; i < 2; i++) begin
			{system_error_event, sleep_event} = (i == 0) ? 2'b10 : 2'b01;
			repeat (2) @(negedge clock);
			chk("interrupt_pending_line_n_q", 32'h0000_0000, {31'h0, interrupt_pending_line_n_q});
			io_read(5'h10, 32'h0000_00AA, "main_status");
			{system_error_event, sleep_event} = 2'b00;
			repeat (2) @(negedge clock);
			chk("interrupt_pending_line_n_q", 32'h0000_0001, {31'h0, interrupt_pending_line_n_q});
		end
		io_write(5'h12, 32'h0000_0009);
		pulse(8);
		io_read(5'h12, 32'h0000_0000, "register_pointer");
		chk("missed_frame_counter_q", 32'h0000_0000, {16'h0, missed_frame_counter_q});
		close_out();
	end
endmodule
